// ===== inc/cpu_ctrl_pkg.sv
// Constants, register map and flag layout of the core control registers
//
// Summary of operation
// [RL1] Frame base is a 16-bit addressing base
// [RL2] Vector table base holds 20-bit table start
// [RL3] Instruction pointer is 20 bits, next instruction
// [RL4] Two 16-bit stacks, exactly one active
// [RL5] Stack select 0 picks interrupt, 1 user
// [RL6] Static base is a 16-bit addressing base
// [RL7] Flag word is 11 bits of status
// [RL8] Carry flag captures ALU carry or borrow
// [RL9] Software keeps debug flag at zero
// [RL10] Zero flag set on zero result
// [RL11] Sign flag set on negative result
// [RL12] Bank select picks register bank 0 or 1
// [RL13] Overflow flag set on overflow
// [RL14] Interrupt enable zero blocks maskable requests
// [RL15] Accepting an interrupt clears interrupt enable
// [RL16] Interrupts and traps 0-31 clear stack select
// [RL17] Priority level is 3 bits, 0 to 7
// [RL18] Accept only priority above current level
// [RL19] Reserved bits written zero, read undefined
// [RL20] Flag bit positions fixed by this layout
package cpu_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] FRAME_OFF = 8'h00;
  localparam logic [7:0] VTAB_OFF = 8'h04;
  localparam logic [7:0] IPTR_OFF = 8'h08;
  localparam logic [7:0] USTACK_OFF = 8'h0c;
  localparam logic [7:0] ISTACK_OFF = 8'h10;
  localparam logic [7:0] STATIC_OFF = 8'h14;
  localparam logic [7:0] FLAGS_OFF = 8'h18;
  localparam logic [7:0] ACTIVE_OFF = 8'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Flag word bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_I = 6;
  localparam int FLG_U = 7;
  localparam int PRIO_LSB = 8;
  localparam int PRIO_MSB = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam logic [15:0] STATIC_RST = 16'h0000;
  localparam logic [19:0] VTAB_RST = 20'h00000;
  localparam logic [19:0] IPTR_RST = 20'h00000;
  localparam logic [15:0] USTACK_RST = 16'h0000;
  localparam logic [15:0] ISTACK_RST = 16'h0000;
  localparam logic [10:0] FLAGS_RST = 11'h000;
  localparam logic [5:0] TRAP_LIMIT = 6'h20;

endpackage

// ===== rtl/cpu_control_registers_and_flags.sv
// Core control registers, flag word, interrupt gate and AXI4-Lite access
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module cpu_control_registers_and_flags
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // ALU flag update from the sequencer
  input wire logic alu_upd_c,
  input wire logic alu_upd_z,
  input wire logic alu_upd_s,
  input wire logic alu_upd_o,
  input wire logic [15:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_overflow,
  // Sequencer loads
  input wire logic ip_we,
  input wire logic [19:0] ip_wdata,
  input wire logic stack_we,
  input wire logic [15:0] stack_wdata,
  // Interrupt and trap
  input wire logic irq_req,
  input wire logic [2:0] irq_priority,
  output logic irq_accept,
  input wire logic trap_exec,
  input wire logic [5:0] trap_number,
  // Register views for the core
  output logic [15:0] frame_base_pointer,
  output logic [15:0] static_base_pointer,
  output logic [19:0] vector_table_base,
  output logic [19:0] instruction_pointer,
  output logic [15:0] user_stack_pointer,
  output logic [15:0] interrupt_stack_pointer,
  output logic [15:0] active_stack_pointer,
  output logic [10:0] cpu_flag_word,
  output logic bank_select,
  output logic debug_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block
  typedef struct packed {
    logic [15:0] frame;     // Frame base
    logic [15:0] stat;      // Static base
    logic [19:0] vtab;      // Vector table start
    logic [19:0] iptr;      // Next instruction
    logic [15:0] ustack;    // User stack
    logic [15:0] istack;    // Interrupt stack
    logic [10:0] flags;     // Flag word
    logic aw_got;           // Write address held
    logic [7:0] awaddr;     // Held write address
    logic w_got;            // Write data held
    logic [31:0] wdata;     // Held write data
    logic [3:0] wstrb;      // Held byte strobes
    logic bvalid;           // Write response pending
    logic [1:0] bresp;      // Write response code
    logic rvalid;           // Read data pending
    logic [31:0] rdata;     // Read data
    logic [1:0] rresp;      // Read response code
  } state_t;

  state_t s_r;              // Registered state
  state_t s_nxt;            // Next state
  logic wr_fire;            // Write committed this cycle
  logic [31:0] wr_mask;     // Byte strobes as bit mask
  logic [31:0] wr_tmp;      // Merged write word

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Handshake outputs, combinational from held state
  // One write and one read in flight; a held half waits for its partner
  assign awready = !s_r.aw_got && !s_r.bvalid;
  assign wready = !s_r.w_got && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_mask = {{8{s_r.wstrb[3]}}, {8{s_r.wstrb[2]}},
                    {8{s_r.wstrb[1]}}, {8{s_r.wstrb[0]}}};

  // Gate: enable set and request strictly above current level
  assign irq_accept = irq_req && s_r.flags[cpu_ctrl_pkg::FLG_I] && // [RL14]
    (irq_priority > s_r.flags[cpu_ctrl_pkg::PRIO_MSB:  // [RL18]
                              cpu_ctrl_pkg::PRIO_LSB]); // [RL17]

  ////////////////////////////////////////////////////////////////////////////
  // Register views straight from flops, except the active stack view, muxed by stack select
  assign bresp = s_r.bresp;
  assign bvalid = s_r.bvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign rvalid = s_r.rvalid;
  assign frame_base_pointer = s_r.frame;            // [RL1]
  assign static_base_pointer = s_r.stat;            // [RL6]
  assign vector_table_base = s_r.vtab;              // [RL2]
  assign instruction_pointer = s_r.iptr;            // [RL3]
  assign user_stack_pointer = s_r.ustack;
  assign interrupt_stack_pointer = s_r.istack;
  assign cpu_flag_word = s_r.flags;                 // [RL7] [RL20]
  assign bank_select = s_r.flags[cpu_ctrl_pkg::FLG_B]; // [RL12]
  assign debug_flag = s_r.flags[cpu_ctrl_pkg::FLG_D];
  // Only one stack is addressed by the core; the other holds its value unless written over the bus
  assign active_stack_pointer = s_r.flags[cpu_ctrl_pkg::FLG_U] ? // [RL4]
    s_r.ustack : s_r.istack;                        // [RL5]

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  // Bus writes land first; core events follow so hardware wins a tie
  always_comb
  begin
    s_nxt = s_r;
    wr_tmp = 32'h00000000;
    // Response retire before new capture
    if (s_r.bvalid && bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    if (awvalid && awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    // Commit a complete write
    if (wr_fire)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = cpu_ctrl_pkg::RESP_OKAY;
      case (s_r.awaddr)
        cpu_ctrl_pkg::FRAME_OFF:
        begin
          wr_tmp = merge({16'h0000, s_r.frame}, s_r.wdata, wr_mask);
          s_nxt.frame = wr_tmp[15:0];                // [RL1]
        end
        cpu_ctrl_pkg::VTAB_OFF:
        begin
          wr_tmp = merge({12'h000, s_r.vtab}, s_r.wdata, wr_mask);
          s_nxt.vtab = wr_tmp[19:0];                 // [RL2]
        end
        cpu_ctrl_pkg::IPTR_OFF:
        begin
          wr_tmp = merge({12'h000, s_r.iptr}, s_r.wdata, wr_mask);
          s_nxt.iptr = wr_tmp[19:0];                 // [RL3]
        end
        cpu_ctrl_pkg::USTACK_OFF:
        begin
          wr_tmp = merge({16'h0000, s_r.ustack}, s_r.wdata, wr_mask);
          s_nxt.ustack = wr_tmp[15:0];               // [RL4]
        end
        cpu_ctrl_pkg::ISTACK_OFF:
        begin
          wr_tmp = merge({16'h0000, s_r.istack}, s_r.wdata, wr_mask);
          s_nxt.istack = wr_tmp[15:0];               // [RL4]
        end
        cpu_ctrl_pkg::STATIC_OFF:
        begin
          wr_tmp = merge({16'h0000, s_r.stat}, s_r.wdata, wr_mask);
          s_nxt.stat = wr_tmp[15:0];                 // [RL6]
        end
        cpu_ctrl_pkg::FLAGS_OFF:
        begin
          // Bits above the word are dropped; software keeps debug at 0
          wr_tmp = merge({21'h000000, s_r.flags}, s_r.wdata, wr_mask);
          s_nxt.flags = wr_tmp[10:0];                // [RL19] [RL9]
        end
        cpu_ctrl_pkg::ACTIVE_OFF:
        begin
          // Read-only view; write accepted and ignored
          s_nxt.bresp = cpu_ctrl_pkg::RESP_OKAY;
        end
        default:
        begin
          s_nxt.bresp = cpu_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Read channel: retire, then capture
    if (s_r.rvalid && rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = cpu_ctrl_pkg::RESP_OKAY;
      case (araddr)
        cpu_ctrl_pkg::FRAME_OFF: s_nxt.rdata = {16'h0000, s_r.frame};
        cpu_ctrl_pkg::VTAB_OFF: s_nxt.rdata = {12'h000, s_r.vtab};
        cpu_ctrl_pkg::IPTR_OFF: s_nxt.rdata = {12'h000, s_r.iptr};
        cpu_ctrl_pkg::USTACK_OFF: s_nxt.rdata = {16'h0000, s_r.ustack};
        cpu_ctrl_pkg::ISTACK_OFF: s_nxt.rdata = {16'h0000, s_r.istack};
        cpu_ctrl_pkg::STATIC_OFF: s_nxt.rdata = {16'h0000, s_r.stat};
        // Unused upper bits read as zero
        cpu_ctrl_pkg::FLAGS_OFF: s_nxt.rdata = {21'h000000, s_r.flags};
        cpu_ctrl_pkg::ACTIVE_OFF:
          s_nxt.rdata = {16'h0000, active_stack_pointer};
        default:
        begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = cpu_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Sequencer loads
    if (ip_we)
    begin
      s_nxt.iptr = ip_wdata;                         // [RL3]
    end
    if (stack_we)
    begin
      // Write goes to whichever stack is active now
      if (s_r.flags[cpu_ctrl_pkg::FLG_U])
        s_nxt.ustack = stack_wdata;                  // [RL5]
      else
        s_nxt.istack = stack_wdata;                  // [RL5]
    end
    // ALU result flags
    if (alu_upd_c)
      s_nxt.flags[cpu_ctrl_pkg::FLG_C] = alu_carry;  // [RL8]
    if (alu_upd_z)
      s_nxt.flags[cpu_ctrl_pkg::FLG_Z] = (alu_result == 16'h0000); // [RL10]
    if (alu_upd_s)
      s_nxt.flags[cpu_ctrl_pkg::FLG_S] = alu_result[15]; // [RL11]
    if (alu_upd_o)
      s_nxt.flags[cpu_ctrl_pkg::FLG_O] = alu_overflow; // [RL13]
    // Interrupt acceptance masks further requests and selects INTERRUPT_STACK_POINTER stack
    if (irq_accept)
    begin
      s_nxt.flags[cpu_ctrl_pkg::FLG_I] = 1'b0;       // [RL15]
      s_nxt.flags[cpu_ctrl_pkg::FLG_U] = 1'b0;       // [RL16]
    end
    // Low-numbered traps run on the interrupt stack
    if (trap_exec && (trap_number < cpu_ctrl_pkg::TRAP_LIMIT))
    begin
      s_nxt.flags[cpu_ctrl_pkg::FLG_U] = 1'b0;       // [RL16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
      s_r.frame <= cpu_ctrl_pkg::FRAME_RST;
      s_r.stat <= cpu_ctrl_pkg::STATIC_RST;
      s_r.vtab <= cpu_ctrl_pkg::VTAB_RST;
      s_r.iptr <= cpu_ctrl_pkg::IPTR_RST;
      s_r.ustack <= cpu_ctrl_pkg::USTACK_RST;
      s_r.istack <= cpu_ctrl_pkg::ISTACK_RST;
      s_r.flags <= cpu_ctrl_pkg::FLAGS_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own outputs
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helpers: bus write to a given register this cycle
  logic wr_frame;
  logic wr_vtab;
  logic wr_flags;
  assign wr_frame = wr_fire && (s_r.awaddr == cpu_ctrl_pkg::FRAME_OFF);
  assign wr_vtab = wr_fire && (s_r.awaddr == cpu_ctrl_pkg::VTAB_OFF);
  assign wr_flags = wr_fire && (s_r.awaddr == cpu_ctrl_pkg::FLAGS_OFF);

  a_frame_hold: assert property ( // [RL1]
    !wr_frame |=> $stable(frame_base_pointer))
    else $error("frame base changed without a write");

  a_vtab_hold: assert property ( // [RL2]
    $changed(vector_table_base) |-> $past(wr_vtab))
    else $error("vector table base changed without a write");

  a_iptr_load: assert property ( // [RL3]
    ip_we |=> instruction_pointer == $past(ip_wdata))
    else $error("instruction pointer did not load");

  a_stack_select: assert property ( // [RL5]
    stack_we && !cpu_flag_word[cpu_ctrl_pkg::FLG_U] |=>
      interrupt_stack_pointer == $past(stack_wdata) &&
      $stable(user_stack_pointer))
    else $error("stack write went to the wrong stack");

  a_zero_flag: assert property ( // [RL10]
    alu_upd_z && !wr_flags |=>
      cpu_flag_word[cpu_ctrl_pkg::FLG_Z] == ($past(alu_result) == 16'h0000))
    else $error("zero flag wrong");

  a_sign_flag: assert property ( // [RL11]
    alu_upd_s && !wr_flags |=>
      cpu_flag_word[cpu_ctrl_pkg::FLG_S] == $past(alu_result[15]))
    else $error("sign flag wrong");

  a_carry_ovf: assert property ( // [RL8] [RL13]
    alu_upd_c && alu_upd_o && !wr_flags |=>
      cpu_flag_word[cpu_ctrl_pkg::FLG_C] == $past(alu_carry) &&
      cpu_flag_word[cpu_ctrl_pkg::FLG_O] == $past(alu_overflow))
    else $error("carry or overflow flag wrong");

  a_irq_gate: assert property ( // [RL14] [RL18]
    irq_accept |-> cpu_flag_word[cpu_ctrl_pkg::FLG_I] &&
      irq_priority > cpu_flag_word[cpu_ctrl_pkg::PRIO_MSB:
                                   cpu_ctrl_pkg::PRIO_LSB])
    else $error("interrupt accepted while masked");

  a_irq_clear: assert property ( // [RL15] [RL16]
    irq_accept |=> !cpu_flag_word[cpu_ctrl_pkg::FLG_I] &&
      !cpu_flag_word[cpu_ctrl_pkg::FLG_U] ##1
      active_stack_pointer == interrupt_stack_pointer)
    else $error("accept did not clear enable and stack select");

  a_trap_clear: assert property ( // [RL16]
    trap_exec && trap_number < cpu_ctrl_pkg::TRAP_LIMIT |=>
      !cpu_flag_word[cpu_ctrl_pkg::FLG_U])
    else $error("low trap did not select interrupt stack");

  a_write_resp: assert property (
    wr_fire |=> bvalid)
    else $error("write response missing");

  // A retired response must not linger into the next write's window
  a_write_retire: assert property (
    bvalid && bready |=> !bvalid)
    else $error("write response did not retire");

  a_read_resp: assert property (
    arvalid && arready |=> rvalid)
    else $error("read data not presented next cycle");

  // Read data is gone once taken, so a stale word is never taken twice
  a_read_retire: assert property (
    rvalid && rready |=> !rvalid)
    else $error("read data did not retire");

  c_irq_taken: cover property (irq_accept ##1 irq_req && !irq_accept);
  c_flag_write: cover property (wr_flags ##1 alu_upd_z);
  c_trap_low: cover property (trap_exec &&
    trap_number < cpu_ctrl_pkg::TRAP_LIMIT);
  c_rd_back: cover property (arvalid && arready ##1 rvalid && rready);

endmodule // cpu_control_registers_and_flags

// ===== tb/cpu_control_registers_and_flags_bench.sv
// Self-checking bench for the core control registers and flag word
module cpu_control_registers_and_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq_accept;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic alu_upd_c = 1'b0, alu_upd_z = 1'b0, alu_upd_s = 1'b0;
  logic alu_upd_o = 1'b0, alu_carry = 1'b0, alu_overflow = 1'b0;
  logic [15:0] alu_result = 16'h0, stack_wdata = 16'h0;
  logic ip_we = 1'b0, stack_we = 1'b0, irq_req = 1'b0, trap_exec = 1'b0;
  logic [19:0] ip_wdata = 20'h0;
  logic [2:0] irq_priority = 3'h0;
  logic [5:0] trap_number = 6'h00;
  logic [15:0] frame_base_pointer, static_base_pointer;
  logic [15:0] user_stack_pointer, interrupt_stack_pointer;
  logic [15:0] active_stack_pointer;
  logic [19:0] vector_table_base, instruction_pointer;
  logic [10:0] cpu_flag_word;
  logic bank_select, debug_flag;
  int failures = 0;
  int check_count = 0;

  // Half period of the 10 MHz clock
  always #50 aclk = ~aclk;

  cpu_control_registers_and_flags u_dut
  (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .alu_upd_c, .alu_upd_z,
    .alu_upd_s, .alu_upd_o, .alu_result, .alu_carry, .alu_overflow,
    .ip_we, .ip_wdata, .stack_we, .stack_wdata, .irq_req, .irq_priority,
    .irq_accept, .trap_exec, .trap_number, .frame_base_pointer,
    .static_base_pointer, .vector_table_base, .instruction_pointer,
    .user_stack_pointer, .interrupt_stack_pointer, .active_stack_pointer,
    .cpu_flag_word, .bank_select, .debug_flag
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic close_out;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: ready is sampled at the falling edge, since it only moves
  // after a rising edge; the transfer itself completes at the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && pb; n++)
    begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      // bready stays high between writes, so no edge sees it toggled twice
      pa = pa && !ta;
      pw = pw && !tw;
      pb = !tb;
    end
    // A lost response ends the run
    if (pb)
    begin
      failures++;
      close_out();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic pa, pr, ta;
    int n;
    pa = 1'b1;
    pr = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && pr; n++)
    begin
      @(negedge aclk);
      ta = pa && arready;
      pr = !rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta)
        arvalid <= 1'b0;
      // rready stays high between reads
      pa = pa && !ta;
    end
    if (pr)
    begin
      failures++;
      close_out();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_map;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++)
    begin
      axi_rd(8'(i * 4), d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(cpu_ctrl_pkg::RESP_OKAY));
    end
    // Unmapped offset answers with an error and no data
    axi_rd(8'h20, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(cpu_ctrl_pkg::RESP_SLVERR));
  endtask

  task automatic t_widths;
    logic [31:0] m [6] = '{32'hffff, 32'hfffff, 32'hfffff, 32'hffff,
      32'hffff, 32'hffff};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++)
      axi_wr(8'(i * 4), 32'hffffff00 | 32'(i), r);
    for (int i = 0; i < 6; i++)
    begin
      axi_rd(8'(i * 4), d, r);
      chk(d, (32'hffffff00 | 32'(i)) & m[i]);
    end
    chk(32'(frame_base_pointer), 32'hff00);
    chk(32'(vector_table_base), 32'hfff01);
    chk(32'(static_base_pointer), 32'hff05);
    // Low byte lane only: the upper byte of the frame base must survive
    wstrb <= 4'h1;
    axi_wr(cpu_ctrl_pkg::FRAME_OFF, 32'h00001234, r);
    wstrb <= 4'hf;
    chk(32'(frame_base_pointer), 32'hff34);
    // Every field set except the debug flag, reserved area left zero
    axi_wr(cpu_ctrl_pkg::FLAGS_OFF, 32'h7fd, r);
    axi_rd(cpu_ctrl_pkg::FLAGS_OFF, d, r);
    chk(d, 32'h7fd);
    axi_rd(cpu_ctrl_pkg::ACTIVE_OFF, d, r);
    chk(d, 32'hff03);
    chk(32'(bank_select), 32'h1);
    chk(32'(debug_flag), 32'h0);
    axi_wr(cpu_ctrl_pkg::FLAGS_OFF, 32'h0, r);
    chk(32'(bank_select), 32'h0);
    // Active view is read only; unmapped write is refused
    axi_wr(cpu_ctrl_pkg::ACTIVE_OFF, 32'h0, r);
    axi_rd(cpu_ctrl_pkg::ACTIVE_OFF, d, r);
    chk(d, 32'hff04);
    axi_wr(8'h20, 32'h1, r);
    chk(32'(r), 32'(cpu_ctrl_pkg::RESP_SLVERR));
  endtask

  task automatic alu_step(input logic [3:0] u, input logic [15:0] res,
    input logic c, input logic o, input logic [10:0] e);
    {alu_upd_c, alu_upd_z, alu_upd_s, alu_upd_o} <= u;
    alu_result <= res;
    alu_carry <= c;
    alu_overflow <= o;
    @(posedge aclk);
    {alu_upd_c, alu_upd_z, alu_upd_s, alu_upd_o} <= 4'h0;
    ip_we <= 1'b0;
    stack_we <= 1'b0;
    @(negedge aclk);
    chk(32'(cpu_flag_word), 32'(e));
    @(posedge aclk);
  endtask

  task automatic t_core;
    // Loads ride along with the first flag update, stack select is zero
    ip_we <= 1'b1;
    ip_wdata <= 20'habcde;
    stack_we <= 1'b1;
    stack_wdata <= 16'h5a5a;
    alu_step(4'hf, 16'h0000, 1'b1, 1'b1, 11'h025);
    chk(32'(instruction_pointer), 32'habcde);
    chk(32'(interrupt_stack_pointer), 32'h5a5a);
    chk(32'(user_stack_pointer), 32'hff03);
    chk(32'(active_stack_pointer), 32'h5a5a);
    alu_step(4'hf, 16'h8000, 1'b0, 1'b0, 11'h008);
    // Only carry enabled: zero result must not touch the zero flag
    alu_step(4'h8, 16'h0000, 1'b1, 1'b1, 11'h009);
  endtask

  task automatic t_irq;
    logic [1:0] r;
    for (int l = 0; l < 8; l++)
    begin
      axi_wr(cpu_ctrl_pkg::FLAGS_OFF, 32'hc0 | 32'(l << 8), r);
      for (int p = 0; p < 8; p++)
      begin
        irq_req <= 1'b1;
        irq_priority <= 3'(p);
        @(negedge aclk);
        chk(32'(irq_accept), 32'(p > l));
        @(posedge aclk);
        if (p > l)
        begin
          @(negedge aclk);
          chk(32'(irq_accept), 32'h0);
          chk(32'(cpu_flag_word), 32'(l << 8));
          @(posedge aclk);
          break;
        end
      end
      irq_req <= 1'b0;
    end
  endtask

  task automatic t_trap;
    logic [5:0] nums [3] = '{6'h00, 6'h1f, 6'h20};
    logic [1:0] r;
    for (int i = 0; i < 3; i++)
    begin
      axi_wr(cpu_ctrl_pkg::FLAGS_OFF, 32'hc0, r);
      trap_exec <= 1'b1;
      trap_number <= nums[i];
      @(posedge aclk);
      trap_exec <= 1'b0;
      @(negedge aclk);
      chk(32'(cpu_flag_word), (i < 2) ? 32'h40 : 32'hc0);
      chk(32'(active_stack_pointer),
        (i < 2) ? 32'h5a5a : 32'hff03);
      @(posedge aclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held for two cycles, then each scenario in turn
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_widths();
    t_core();
    t_irq();
    t_trap();
    close_out();
  end

endmodule // cpu_control_registers_and_flags_bench
